// ===== verilog/fpc_pkg.sv
// Package of the flash protection and configuration register block.
// Assumes a 100 MHz ref_clk and a 32-bit AHB-Lite register bus.
package fpc_pkg;

   // Register byte offsets.
   localparam logic [7:0] FPC_OFS_STATUS = 8'h00;
   localparam logic [7:0] FPC_OFS_CONFIG = 8'h04;
   localparam logic [7:0] FPC_OFS_CMD = 8'h08;
   localparam logic [7:0] FPC_OFS_MODE = 8'h0C;

   // Status register fields.
   localparam int FPC_ST_BUSY = 0;
   localparam int FPC_ST_LVL_LO = 2;
   localparam int FPC_ST_LVL_HI = 3;
   localparam int FPC_ST_LOCK = 7;

   // Configuration register fields.
   localparam int FPC_CF_IOC = 1;
   localparam int FPC_CF_VLP = 2;
   localparam int FPC_CF_SEC = 3;
   localparam int FPC_CF_WSE = 4;
   localparam int FPC_CF_WSP = 5;
   localparam int FPC_CF_PINF = 6;
   localparam int FPC_CF_WRITE_PROTECT_ENABLE = 7;

   // Mode register field.
   localparam int FPC_MD_QUAD = 0;

   // Reset value of the two protection level bits.
   localparam logic [1:0] FPC_LEVEL_RESET = 2'h3;

   // Command codes written to the command register.
   localparam logic [7:0] FPC_CMD_LOCKDOWN = 8'h01;
   localparam logic [7:0] FPC_CMD_SID_LOCKOUT = 8'h02;
   localparam logic [7:0] FPC_CMD_SUSPEND = 8'h03;
   localparam logic [7:0] FPC_CMD_RESUME = 8'h04;
   localparam logic [7:0] FPC_CMD_SOFT_RESET = 8'h05;
   localparam logic [7:0] FPC_CMD_ENTER_QUAD = 8'h06;
   localparam logic [7:0] FPC_CMD_EXIT_QUAD = 8'h07;

   // Serial opcodes that need the I/O configuration bit or quad command mode.
   localparam logic [7:0] FPC_OP_QUAD_OUT_READ = 8'h6B;
   localparam logic [7:0] FPC_OP_QUAD_IO_READ = 8'hEB;
   localparam logic [7:0] FPC_OP_QUAD_PAGE_PROG = 8'h32;
   localparam logic [7:0] FPC_OP_WRAP_BURST = 8'hEC;

   // Array address width and protected region bases.
   localparam int FPC_ADDR_W = 18;
   localparam logic [17:0] FPC_QUARTER_BASE = 18'h30000;
   localparam logic [17:0] FPC_HALF_BASE = 18'h20000;

   // Self-timed nonvolatile write time, a least time rounded up.
   localparam int FPC_CLK_MHZ = 100;
   localparam int FPC_CFG_WRITE_TIME_NS = 1000;
   localparam int FPC_CFG_WRITE_CYCLES =
      (FPC_CFG_WRITE_TIME_NS * FPC_CLK_MHZ + 999) / 1000;
   localparam int FPC_CNT_W = 16;

   // Register selected by a bus address.
   typedef enum logic [2:0] {
      FPC_SEL_NONE,
      FPC_SEL_STATUS,
      FPC_SEL_CONFIG,
      FPC_SEL_CMD,
      FPC_SEL_MODE
   } fpc_sel_e;

endpackage

// ===== verilog/fpc_link_if.sv
// Interface carrying the synchronised serial-side pin levels.
// Assumes both ends run on ref_clk.
interface fpc_link_if;
   logic sclk_rise;
   logic wp_low;
   logic rst_hold_low;

   modport sampler (
      output sclk_rise,
      output wp_low,
      output rst_hold_low
   );

   modport core (
      input sclk_rise,
      input wp_low,
      input rst_hold_low
   );
endinterface

// ===== verilog/fpc_pin_sync.sv
// Pin synchroniser for the serial clock, write-protect and reset/hold pins.
// Assumes raw pin levels asynchronous to ref_clk.
module fpc_pin_sync (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Raw pins
   input wire logic sclk,
   input wire logic wp_n,
   input wire logic rst_hold_n,
   // Synchronised levels and events
   fpc_link_if.sampler link
);
   import fpc_pkg::*;

   logic [1:0] sclk_meta;
   logic [1:0] wp_meta;
   logic [1:0] rh_meta;
   logic sclk_last;

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sclk_meta <= 2'h0;
         wp_meta <= 2'h3;
         rh_meta <= 2'h3;
         sclk_last <= 1'b0;
      end else begin
         sclk_meta <= {sclk_meta[0], sclk};
         wp_meta <= {wp_meta[0], wp_n};
         rh_meta <= {rh_meta[0], rst_hold_n};
         sclk_last <= sclk_meta[1];
      end
   end

   // Only the second stage of each synchroniser feeds logic.
   assign link.sclk_rise = sclk_meta[1] & ~sclk_last;
   assign link.wp_low = ~wp_meta[1];
   assign link.rst_hold_low = ~rh_meta[1];

endmodule

// ===== verilog/fpc_regs.sv
// Protection and configuration registers of a quad-I/O serial flash.
// Assumes an AHB-Lite master on ref_clk standing in for the command
// decoder, and raw serial-side pins that are asynchronous to ref_clk.

module fpc_regs (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // Serial-side pins
   input wire logic sclk,
   input wire logic wp_n,
   input wire logic rst_hold_n,
   // Array and command side
   input wire logic erase_active,
   input wire logic program_active,
   input wire logic [7:0] opcode,
   input wire logic [fpc_pkg::FPC_ADDR_W-1:0] check_addr,
   input wire logic check_write,
   output logic opcode_valid,
   output logic write_rejected,
   // Nonvolatile storage
   input wire logic nv_restore_pin_function,
   input wire logic nv_restore_write_protect,
   input wire logic nv_restore_secure_id,
   output logic pin_function_select,
   output logic write_protect_enable,
   output logic secure_id_locked,
   // Protection and pin roles
   output logic protect_level_hi,
   output logic protect_level_lo,
   output logic hw_write_protect,
   output logic data_lines_enabled,
   output logic hold_pin_enabled,
   output logic reset_pin_enabled,
   output logic hw_reset_request,
   output logic config_busy
);
   import fpc_pkg::*;

   function automatic fpc_sel_e decode_sel(input logic [31:0] addr);
      fpc_sel_e sel;
      sel = FPC_SEL_NONE;
      if (addr[31:8] == 24'h000000) begin
         if (addr[7:0] == FPC_OFS_STATUS) sel = FPC_SEL_STATUS;
         else if (addr[7:0] == FPC_OFS_CONFIG) sel = FPC_SEL_CONFIG;
         else if (addr[7:0] == FPC_OFS_CMD) sel = FPC_SEL_CMD;
         else if (addr[7:0] == FPC_OFS_MODE) sel = FPC_SEL_MODE;
      end
      return sel;
   endfunction

   function automatic logic in_protected(input logic [1:0] level,
                                         input logic [17:0] addr);
      logic hit;
      hit = 1'b0;
      unique case (level)
         2'h0: hit = 1'b0;
         2'h1: hit = (addr >= FPC_QUARTER_BASE);
         2'h2: hit = (addr >= FPC_HALF_BASE);
         2'h3: hit = 1'b1;
      endcase
      return hit;
   endfunction

   function automatic logic is_quad_op(input logic [7:0] op);
      return (op == FPC_OP_QUAD_OUT_READ) || (op == FPC_OP_QUAD_IO_READ) ||
         (op == FPC_OP_QUAD_PAGE_PROG) || (op == FPC_OP_WRAP_BURST);
   endfunction

   localparam logic [FPC_CNT_W-1:0] CFG_CYCLES =
      FPC_CNT_W'(FPC_CFG_WRITE_CYCLES);

   fpc_link_if link ();

   fpc_pin_sync u_sync (
      .ref_clk(ref_clk),
      .reset(reset),
      .sclk(sclk),
      .wp_n(wp_n),
      .rst_hold_n(rst_hold_n),
      .link(link.sampler)
   );

   // Register state.
   logic protect_lock_bit;
   logic io_config_bit;
   logic volatile_lock_bit;
   logic erase_suspended;
   logic program_suspended;
   logic four_wire_command_mode;
   logic [FPC_CNT_W-1:0] nv_count;
   logic [1:0] nv_data;

   // Bus state.
   logic dp_valid;
   logic dp_write;
   fpc_sel_e dp_sel;
   logic pend_valid;
   fpc_sel_e pend_sel;
   logic [7:0] pend_data;

   // Pin roles and protection.
   logic data_lines;
   logic hw_wp;
   logic lock_effective;
   logic levels_frozen;
   logic hw_reset;
   assign data_lines = io_config_bit | four_wire_command_mode;
   assign hw_wp = link.wp_low & ~data_lines & write_protect_enable;
   assign lock_effective = protect_lock_bit & hw_wp;
   assign levels_frozen = lock_effective | volatile_lock_bit;
   assign hw_reset = ~data_lines & pin_function_select &
      link.rst_hold_low;

   // Bus decode.
   logic ap_take;
   fpc_sel_e ap_sel;
   logic wr_capture;
   logic stall_next;
   assign ap_take = hsel & htrans[1] & hready;
   assign ap_sel = decode_sel(haddr);
   assign wr_capture = dp_valid & dp_write & hreadyout;
   assign stall_next = pend_valid | wr_capture;

   // Writes take effect on the next serial clock rising edge, as a
   // serial command would; a second write stalls the bus until then.
   logic apply;
   logic st_wr;
   logic cf_wr;
   logic cmd_wr;
   assign apply = pend_valid & link.sclk_rise;
   assign st_wr = apply & (pend_sel == FPC_SEL_STATUS);
   assign cf_wr = apply & (pend_sel == FPC_SEL_CONFIG);
   assign cmd_wr = apply & (pend_sel == FPC_SEL_CMD);

   logic lock_wr_ok;
   logic level_wr_ok;
   logic cf_ok;
   logic nv_start;
   logic nv_done;
   assign lock_wr_ok = st_wr & ~hw_wp;
   assign level_wr_ok = st_wr & ~levels_frozen;
   assign cf_ok = cf_wr & ~hw_wp & ~config_busy;
   assign nv_start = cf_ok &
      ((pend_data[FPC_CF_PINF] != pin_function_select) ||
       (pend_data[FPC_CF_WRITE_PROTECT_ENABLE] != write_protect_enable));
   assign nv_done = config_busy & (nv_count == FPC_CNT_W'(1));

   logic do_lockdown;
   logic do_sid_lock;
   logic do_suspend;
   logic do_resume;
   logic do_soft_reset;
   logic do_enter_quad;
   logic do_exit_quad;
   assign do_lockdown = cmd_wr & (pend_data == FPC_CMD_LOCKDOWN);
   assign do_sid_lock = cmd_wr & (pend_data == FPC_CMD_SID_LOCKOUT);
   assign do_suspend = cmd_wr & (pend_data == FPC_CMD_SUSPEND);
   assign do_resume = cmd_wr & (pend_data == FPC_CMD_RESUME);
   assign do_soft_reset = cmd_wr & (pend_data == FPC_CMD_SOFT_RESET);
   assign do_enter_quad = cmd_wr & (pend_data == FPC_CMD_ENTER_QUAD);
   assign do_exit_quad = cmd_wr & (pend_data == FPC_CMD_EXIT_QUAD);

   // Read words.
   logic [31:0] status_word;
   logic [31:0] config_word;
   logic [31:0] mode_word;
   logic [31:0] rd_word;
   always_comb begin
      status_word = 32'h00000000;
      status_word[FPC_ST_BUSY] = config_busy;
      status_word[FPC_ST_LVL_LO] = protect_level_lo;
      status_word[FPC_ST_LVL_HI] = protect_level_hi;
      status_word[FPC_ST_LOCK] = protect_lock_bit;
      config_word = 32'h00000000;
      config_word[FPC_CF_IOC] = io_config_bit;
      config_word[FPC_CF_VLP] = volatile_lock_bit;
      config_word[FPC_CF_SEC] = secure_id_locked;
      config_word[FPC_CF_WSE] = erase_suspended;
      config_word[FPC_CF_WSP] = program_suspended;
      config_word[FPC_CF_PINF] = pin_function_select;
      config_word[FPC_CF_WRITE_PROTECT_ENABLE] = write_protect_enable;
      mode_word = 32'h00000000;
      mode_word[FPC_MD_QUAD] = four_wire_command_mode;
   end
   assign rd_word = (ap_sel == FPC_SEL_STATUS) ? status_word :
      (ap_sel == FPC_SEL_CONFIG) ? config_word :
      (ap_sel == FPC_SEL_MODE) ? mode_word : 32'h00000000;

   // AHB-Lite data phase; every answer is OKAY.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_sel <= FPC_SEL_NONE;
         hreadyout <= 1'b1;
         hrdata <= 32'h00000000;
         hresp <= 1'b0;
      end else if (hreadyout) begin
         dp_valid <= ap_take;
         dp_write <= hwrite;
         dp_sel <= ap_sel;
         hrdata <= (ap_take & ~hwrite) ? rd_word : 32'h00000000;
         hreadyout <= ~(ap_take & hwrite & stall_next);
      end else begin
         hreadyout <= ~pend_valid;
      end
   end

   // Pending write, dropped by a hardware reset.
   always_ff @(posedge ref_clk) begin
      if (reset || hw_reset) begin
         pend_valid <= 1'b0;
         pend_sel <= FPC_SEL_NONE;
         pend_data <= 8'h00;
      end else if (wr_capture) begin
         pend_valid <= 1'b1;
         pend_sel <= dp_sel;
         pend_data <= hwdata[7:0];
      end else if (apply) begin
         pend_valid <= 1'b0;
      end
   end

   // Status register bits.
   always_ff @(posedge ref_clk) begin
      if (reset || hw_reset) begin
         protect_lock_bit <= 1'b0;
         protect_level_hi <= FPC_LEVEL_RESET[1];
         protect_level_lo <= FPC_LEVEL_RESET[0];
      end else begin
         if (lock_wr_ok) begin
            protect_lock_bit <= pend_data[FPC_ST_LOCK];
         end
         if (level_wr_ok) begin
            protect_level_hi <= pend_data[FPC_ST_LVL_HI];
            protect_level_lo <= pend_data[FPC_ST_LVL_LO];
         end
      end
   end

   // Volatile configuration bits. A power-up or pin reset clears them
   // all; a soft reset spares the volatile lock.
   always_ff @(posedge ref_clk) begin
      if (reset || hw_reset) begin
         io_config_bit <= 1'b0;
         volatile_lock_bit <= 1'b0;
         erase_suspended <= 1'b0;
         program_suspended <= 1'b0;
         four_wire_command_mode <= 1'b0;
      end else if (do_soft_reset) begin
         io_config_bit <= 1'b0;
         erase_suspended <= 1'b0;
         program_suspended <= 1'b0;
         four_wire_command_mode <= 1'b0;
      end else begin
         if (cf_ok) begin
            io_config_bit <= pend_data[FPC_CF_IOC];
         end
         if (do_lockdown) begin
            volatile_lock_bit <= 1'b1;
         end
         if (do_suspend && erase_active) begin
            erase_suspended <= 1'b1;
         end else if (do_suspend && program_active) begin
            program_suspended <= 1'b1;
         end
         // A program suspended inside a suspended erase resumes first.
         if (do_resume && program_suspended) begin
            program_suspended <= 1'b0;
         end else if (do_resume) begin
            erase_suspended <= 1'b0;
         end
         if (do_enter_quad) begin
            four_wire_command_mode <= 1'b1;
         end else if (do_exit_quad) begin
            four_wire_command_mode <= 1'b0;
         end
      end
   end

   // Nonvolatile bits: restored at power-up, untouched by other resets.
   // A pin reset aborts a running write and keeps the old values.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pin_function_select <= nv_restore_pin_function;
         write_protect_enable <= nv_restore_write_protect;
         secure_id_locked <= nv_restore_secure_id;
         config_busy <= 1'b0;
         nv_count <= '0;
         nv_data <= 2'h0;
      end else begin
         if (do_sid_lock) begin
            secure_id_locked <= 1'b1;
         end
         if (hw_reset) begin
            config_busy <= 1'b0;
         end else if (nv_start) begin
            config_busy <= 1'b1;
            nv_count <= CFG_CYCLES;
            nv_data <= {pend_data[FPC_CF_WRITE_PROTECT_ENABLE], pend_data[FPC_CF_PINF]};
         end else if (nv_done) begin
            config_busy <= 1'b0;
            write_protect_enable <= nv_data[1];
            pin_function_select <= nv_data[0];
         end else if (config_busy) begin
            nv_count <= nv_count - FPC_CNT_W'(1);
         end
      end
   end

   // Registered outputs for the pins and the command decoder.
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         hw_write_protect <= 1'b0;
         data_lines_enabled <= 1'b0;
         hold_pin_enabled <= 1'b0;
         reset_pin_enabled <= 1'b0;
         hw_reset_request <= 1'b0;
         opcode_valid <= 1'b0;
         write_rejected <= 1'b0;
      end else begin
         hw_write_protect <= hw_wp;
         data_lines_enabled <= data_lines;
         hold_pin_enabled <= ~data_lines & ~pin_function_select;
         reset_pin_enabled <= ~data_lines & pin_function_select;
         hw_reset_request <= hw_reset;
         opcode_valid <= ~is_quad_op(opcode) | data_lines;
         write_rejected <= check_write & in_protected(
            {protect_level_hi, protect_level_lo}, check_addr);
      end
   end

endmodule

// ===== tb/fpc_regs_assertions.sv
// Concurrent checks on the ports of the protection and configuration block.
// Assumes it is bound to fpc_regs and sees only that module's ports.
module fpc_regs_assertions (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Register bus
   input wire logic hsel, hwrite, hready, hreadyout, hresp,
   input wire logic [1:0] htrans,
   // Pins and qualification
   input wire logic wp_n, check_write, opcode_valid, write_rejected,
   input wire logic [7:0] opcode,
   input wire logic [17:0] check_addr,
   // State and derived levels
   input wire logic pin_function_select, write_protect_enable,
   input wire logic secure_id_locked, protect_level_hi, protect_level_lo,
   input wire logic hw_write_protect, data_lines_enabled,
   input wire logic hold_pin_enabled, reset_pin_enabled, config_busy
);
   timeunit 1ns;
   timeprecision 100ps;
   import fpc_pkg::*;
   logic [15:0] busy_cnt;
   wire logic [1:0] lvl = {protect_level_hi, protect_level_lo};
   wire logic quad_op = opcode == FPC_OP_QUAD_OUT_READ ||
      opcode == FPC_OP_QUAD_IO_READ || opcode == FPC_OP_QUAD_PAGE_PROG ||
      opcode == FPC_OP_WRAP_BURST;
   wire logic in_range = lvl == 2'h3 ||
      (lvl == 2'h2 && check_addr >= FPC_HALF_BASE) ||
      (lvl == 2'h1 && check_addr >= FPC_QUARTER_BASE);
   wire logic rej_exp = check_write && in_range;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (reset);

   // Counts busy cycles so the self-timed write length can be bounded.
   always_ff @(posedge ref_clk) begin
      if (reset || !config_busy)
         busy_cnt <= 16'h0000;
      else
         busy_cnt <= busy_cnt + 16'h0001;
   end

   a_okay_resp: assert property (hresp == 1'b0)
      else $error("bus response other than okay");
   a_read_no_wait: assert property (hsel && htrans[1] && hready && !hwrite
      |=> hreadyout) else $error("read answered with a wait state");
   a_range_reject: assert property (!$past(reset) |->
      write_rejected == $past(rej_exp)) else $error("range reject wrong");
   a_quad_gate: assert property (!$past(reset) && $past(quad_op)
      |-> opcode_valid == data_lines_enabled) else $error("quad gate wrong");
   a_plain_op_ok: assert property (!$past(reset) && !$past(quad_op)
      |-> opcode_valid) else $error("plain opcode refused");
   a_pin_high_free: assert property (wp_n [*6]
      |-> !hw_write_protect) else $error("protection with pin high");
   a_enable_needed: assert property (!write_protect_enable ##1
      !write_protect_enable |-> !hw_write_protect)
      else $error("protection without enable bit");
   a_data_lines_free: assert property (data_lines_enabled
      |-> !hw_write_protect && !hold_pin_enabled && !reset_pin_enabled)
      else $error("control roles while pins carry data");
   a_role_select: assert property (!$past(reset) &&
      (reset_pin_enabled || hold_pin_enabled)
      |-> reset_pin_enabled == $past(pin_function_select))
      else $error("pin role differs from pin-function bit");
   a_busy_time: assert property ($fell(config_busy)
      |-> busy_cnt >= FPC_CFG_WRITE_CYCLES &&
      busy_cnt <= FPC_CFG_WRITE_CYCLES + 1)
      else $error("self-timed write length wrong");
   a_nv_quiet: assert property (!$past(reset) && !$past(config_busy) &&
      !$past(config_busy, 2) |-> $stable(write_protect_enable) &&
      $stable(pin_function_select)) else $error("nonvolatile bit moved");
   a_sid_sticky: assert property (secure_id_locked
      |=> secure_id_locked) else $error("security lock bit cleared");
   a_level_reset: assert property ($fell(reset)
      |-> protect_level_hi && protect_level_lo) else $error("levels not 11");
endmodule

// ===== tb/fpc_host_model.sv
// Behavioural serial host driving the serial clock and control pins.
// Assumes the bench opens a frame around each register write.
module fpc_host_model (
   // Control from the bench
   input wire logic frame,
   input wire logic wp_lvl,
   input wire logic rh_lvl,
   // Serial-side pins
   output logic sclk,
   output logic wp_n,
   output logic rst_hold_n
);
   timeunit 1ns;
   timeprecision 100ps;
   initial sclk = 1'b0;
   // The clock stands still low outside frames, as a real host leaves it.
   always begin
      wait (frame === 1'b1);
      // A frame closed during the low half gives no further rising edge.
      #62.5 sclk = (frame === 1'b1);
      #62.5 sclk = 1'b0;
   end
   assign wp_n = wp_lvl;
   assign rst_hold_n = rh_lvl;
endmodule

// ===== tb/tb.sv
// Self-checking bench for the protection and configuration registers.
// Assumes fpc_regs, its package and the host model are compiled first.
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import fpc_pkg::*;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic hsel = 1'b0, hwrite = 1'b0, check_write = 1'b0;
   logic erase_active = 1'b0, program_active = 1'b0;
   logic nv_restore_pin_function = 1'b0, nv_restore_write_protect = 1'b0;
   logic nv_restore_secure_id = 1'b0, frame = 1'b0;
   logic wp_lvl = 1'b1, rh_lvl = 1'b1;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [7:0] opcode = 8'h00;
   logic [17:0] check_addr = 18'h0;
   logic hreadyout, hresp, sclk, wp_n, rst_hold_n, opcode_valid;
   logic write_rejected, pin_function_select, write_protect_enable;
   logic secure_id_locked, protect_level_hi, protect_level_lo;
   logic hw_write_protect, data_lines_enabled, hold_pin_enabled;
   logic reset_pin_enabled, hw_reset_request, config_busy;
   int error_cnt = 0, checked = 0, cyc = 0;
   logic [7:0] ops [4] = '{8'h6B, 8'hEB, 8'h32, 8'hEC};
   logic [17:0] adrs [6] = '{18'h00000, 18'h1FFFF, 18'h20000, 18'h2FFFF,
      18'h30000, 18'h3FFFF};

   fpc_regs fpc_regs_inst (.ref_clk, .reset, .hsel, .haddr, .htrans,
      .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout,
      .hrdata, .hresp, .sclk, .wp_n, .rst_hold_n, .erase_active,
      .program_active, .opcode, .check_addr, .check_write, .opcode_valid,
      .write_rejected, .nv_restore_pin_function, .nv_restore_write_protect,
      .nv_restore_secure_id, .pin_function_select, .write_protect_enable,
      .secure_id_locked, .protect_level_hi, .protect_level_lo,
      .hw_write_protect, .data_lines_enabled, .hold_pin_enabled,
      .reset_pin_enabled, .hw_reset_request, .config_busy);
   fpc_host_model fpc_host_model_inst (.frame, .wp_lvl, .rh_lvl, .sclk,
      .wp_n, .rst_hold_n);

   always #5 ref_clk = ~ref_clk;

   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         complete_run;
      end
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   // One single word transfer; waits as long as the slave holds ready low.
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge ref_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // Writes land on a serial clock edge, so each write gets a short frame.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
      frame <= 1'b1;
      repeat (30) @(posedge ref_clk);
      frame <= 1'b0;
      repeat (6) @(posedge ref_clk);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 8'h00);
      chk(rd, e);
   endtask

   task automatic probe(input logic [7:0] op, input logic [17:0] ad);
      @(posedge ref_clk);
      opcode <= op;
      check_addr <= ad;
      check_write <= 1'b1;
      repeat (2) @(posedge ref_clk);
   endtask

   task automatic quad_ops(input logic e);
      for (int i = 0; i < 4; i++) begin
         probe(ops[i], 18'h0);
         chk(opcode_valid, e);
      end
   endtask

   task automatic wait_idle;
      do bus(1'b0, FPC_OFS_STATUS, 8'h00); while (rd[FPC_ST_BUSY] !== 1'b0);
   endtask

   task automatic settle;
      repeat (8) @(posedge ref_clk);
   endtask

   function automatic logic rej(int l, logic [17:0] a);
      return l == 3 || (l == 2 && a >= FPC_HALF_BASE) ||
         (l == 1 && a >= FPC_QUARTER_BASE);
   endfunction

   initial begin
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      rchk(FPC_OFS_STATUS, 32'h0C);
      rchk(FPC_OFS_CONFIG, 32'h00);
      wr(FPC_OFS_CONFIG, 8'h01);
      rchk(FPC_OFS_CONFIG, 32'h00);
      rchk(8'h10, 32'h00);
      for (int l = 0; l < 4; l++) begin
         wr(FPC_OFS_STATUS, 8'(l << 2));
         rchk(FPC_OFS_STATUS, 32'(l << 2));
         for (int k = 0; k < 6; k++) begin
            probe(8'h03, adrs[k]);
            chk(write_rejected, rej(l, adrs[k]));
         end
      end
      quad_ops(1'b0);
      // The host must set the I/O bit or enter quad command mode before any quad opcode.
      wr(FPC_OFS_CONFIG, 8'h02);
      rchk(FPC_OFS_CONFIG, 32'h02);
      chk(data_lines_enabled, 1'b1);
      quad_ops(1'b1);
      wr(FPC_OFS_CMD, FPC_CMD_SOFT_RESET);
      rchk(FPC_OFS_CONFIG, 32'h00);
      chk(hold_pin_enabled, 1'b1);
      wr(FPC_OFS_CMD, FPC_CMD_ENTER_QUAD);
      rchk(FPC_OFS_MODE, 32'h01);
      quad_ops(1'b1);
      wr(FPC_OFS_CMD, FPC_CMD_EXIT_QUAD);
      quad_ops(1'b0);
      for (int i = 0; i < 2; i++) begin
         erase_active <= (i == 0);
         program_active <= (i == 1);
         wr(FPC_OFS_CMD, FPC_CMD_SUSPEND);
         rchk(FPC_OFS_CONFIG, i ? 32'h20 : 32'h10);
         wr(FPC_OFS_CMD, FPC_CMD_RESUME);
         rchk(FPC_OFS_CONFIG, 32'h00);
      end
      program_active <= 1'b0;
      wr(FPC_OFS_CMD, FPC_CMD_SID_LOCKOUT);
      rchk(FPC_OFS_CONFIG, 32'h08);
      wr(FPC_OFS_STATUS, 8'h04);
      wr(FPC_OFS_CMD, FPC_CMD_LOCKDOWN);
      rchk(FPC_OFS_CONFIG, 32'h0C);
      wr(FPC_OFS_STATUS, 8'h00);
      rchk(FPC_OFS_STATUS, 32'h04);
      wr(FPC_OFS_CMD, FPC_CMD_SOFT_RESET);
      rchk(FPC_OFS_CONFIG, 32'h0C);
      wr(FPC_OFS_CONFIG, 8'h40);
      chk(config_busy, 1'b1);
      wait_idle;
      rchk(FPC_OFS_CONFIG, 32'h4C);
      chk(reset_pin_enabled, 1'b1);
      rh_lvl <= 1'b0;
      settle;
      chk(hw_reset_request, 1'b1);
      rh_lvl <= 1'b1;
      settle;
      rchk(FPC_OFS_CONFIG, 32'h48);
      rchk(FPC_OFS_STATUS, 32'h0C);
      wr(FPC_OFS_STATUS, 8'h80);
      wr(FPC_OFS_STATUS, 8'h84);
      rchk(FPC_OFS_STATUS, 32'h84);
      wr(FPC_OFS_CONFIG, 8'hC0);
      wait_idle;
      rchk(FPC_OFS_CONFIG, 32'hC8);
      wp_lvl <= 1'b0;
      settle;
      chk(hw_write_protect, 1'b1);
      wr(FPC_OFS_STATUS, 8'h0C);
      rchk(FPC_OFS_STATUS, 32'h84);
      wr(FPC_OFS_CONFIG, 8'h42);
      rchk(FPC_OFS_CONFIG, 32'hC8);
      wr(FPC_OFS_CMD, FPC_CMD_ENTER_QUAD);
      rchk(FPC_OFS_MODE, 32'h01);
      chk(hw_write_protect, 1'b0);
      wr(FPC_OFS_STATUS, 8'h0C);
      rchk(FPC_OFS_STATUS, 32'h0C);
      wr(FPC_OFS_CMD, FPC_CMD_EXIT_QUAD);
      wp_lvl <= 1'b1;
      settle;
      chk(hw_write_protect, 1'b0);
      nv_restore_write_protect <= 1'b1;
      nv_restore_secure_id <= 1'b1;
      reset <= 1'b1;
      repeat (12) @(posedge ref_clk);
      reset <= 1'b0;
      rchk(FPC_OFS_CONFIG, 32'h88);
      rchk(FPC_OFS_STATUS, 32'h0C);
      chk({protect_level_hi, protect_level_lo}, 32'h3);
      chk({write_protect_enable, secure_id_locked}, 32'h3);
      chk(pin_function_select, 32'h0);
      complete_run;
   end
endmodule

bind fpc_regs fpc_regs_assertions fpc_regs_assertions_inst (.ref_clk,
   .reset, .hsel, .hwrite, .hready, .hreadyout, .hresp, .htrans, .wp_n,
   .check_write, .opcode_valid, .write_rejected, .opcode, .check_addr,
   .pin_function_select, .write_protect_enable, .secure_id_locked,
   .protect_level_hi, .protect_level_lo, .hw_write_protect,
   .data_lines_enabled, .hold_pin_enabled, .reset_pin_enabled,
   .config_busy);
